// *** rtl/ras_pkg.sv ***
// Purpose: Shared constants and types for the return-address stack block.
// Assumes: One instruction clock; the sequencer issues at most one stack operation per cycle.
// Notes: The pointer reset values, the limits and the counts used by the block live here; stack entries and saved flag words have no reset.
package ras_pkg;
    localparam int PC_WIDTH = 11;
    localparam int SP_WIDTH = 3;
    localparam int ENTRY_COUNT = 5;
    localparam int FLAG_WIDTH = 5;
    localparam int FLAG_LEVELS = 3;
    localparam int ROM_WIDTH = 16;
    localparam logic [2:0] SP_RESET = 3'h5;
    localparam logic [2:0] SP_LIMIT = 3'h6;
    localparam logic [2:0] SP_WRAP = 3'h7;
    localparam logic [1:0] FLAG_PTR_RESET = 2'h0;

    // Operation codes issued by the instruction sequencer.
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_CALL = 4'h1,
        OP_RETURN = 4'h2,
        OP_RETURN_SKIP = 4'h3,
        OP_TABLE_FIRST = 4'h4,
        OP_TABLE_SECOND = 4'h5,
        OP_INTERRUPT = 4'h6,
        OP_RETURN_INT = 4'h7,
        OP_PUSH = 4'h8,
        OP_POP = 4'h9
    } stack_op_type;

    // Table read sequencing state.
    typedef enum logic [0:0] {
        TABLE_IDLE = 1'h0,
        TABLE_FETCH = 1'h1
    } table_state_type;
endpackage : ras_pkg

// *** rtl/stack_pointer_if.sv ***
// Purpose: Carries the stack pointer step requests and the current pointer.
// Assumes: Driven on the instruction clock.
// Notes: Shared between the top and the pointer unit.
`timescale 1ns/1ns
interface stack_pointer_if;
    logic dec;
    logic inc;
    logic [2:0] value;
    logic [2:0] next_value;
    logic underflow;
    modport owner (input dec, input inc, output value, output next_value, output underflow);
    modport user (output dec, output inc, input value, input next_value, input underflow);
endinterface : stack_pointer_if

// *** rtl/stack_pointer_unit.sv ***
// Purpose: Three-bit wrapping stack pointer with underflow detection.
// Assumes: dec and inc are never raised together.
// Notes: The next value is exported so entry writes use the decremented pointer.
`timescale 1ns/1ns
module stack_pointer_unit
(
    input wire logic clock_in,
    input wire logic srst_in,
    stack_pointer_if.owner sp
);
    logic [2:0] stack_pointer;

    // Pointer moves by exactly one and wraps freely.
    always_comb
    begin
        if (sp.dec)
            sp.next_value = stack_pointer - 3'h1;
        else if (sp.inc)
            sp.next_value = stack_pointer + 3'h1;
        else
            sp.next_value = stack_pointer;
    end

    // A decrement from zero wraps to seven and is flagged as a fault.
    assign sp.underflow = sp.dec && (stack_pointer == 3'h0);
    assign sp.value = stack_pointer;

    // Reset leaves the pointer one above the top entry.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            stack_pointer <= ras_pkg::SP_RESET;
        else
            stack_pointer <= sp.next_value;
    end
endmodule : stack_pointer_unit

// *** rtl/interrupt_flag_stack.sv ***
// Purpose: Three-level circular store of saved status flags.
// Assumes: save and restore are never raised together.
// Notes: Deeper nesting overwrites the oldest level.
`timescale 1ns/1ns
module interrupt_flag_stack #(
    parameter int LEVELS = ras_pkg::FLAG_LEVELS,
    parameter int WIDTH = ras_pkg::FLAG_WIDTH
)
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic save_in,
    input wire logic restore_in,
    input wire logic [WIDTH-1:0] flags_in,
    output logic [WIDTH-1:0] flags_out
);
    logic [WIDTH-1:0] interrupt_flag_stack [LEVELS];
    logic [1:0] level;

    function automatic logic [1:0] step_down(input logic [1:0] v);
        step_down = (v == 2'h0) ? 2'(LEVELS - 1) : v - 2'h1;
    endfunction : step_down

    // The top of the ring is the level below the write pointer.
    assign flags_out = interrupt_flag_stack[step_down(level)];

    // Ring pointer: a fourth save reuses the oldest slot, losing it.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            level <= ras_pkg::FLAG_PTR_RESET;
        else if (save_in)
            level <= (level == 2'(LEVELS - 1)) ? 2'h0 : level + 2'h1;
        else if (restore_in)
            level <= step_down(level);
    end

    // Flag contents need no reset; they are read only after a save.
    always_ff @(posedge clock_in)
    begin
        if (save_in)
            interrupt_flag_stack[level] <= flags_in;
    end
endmodule : interrupt_flag_stack

// *** rtl/return_address_stack.sv ***
// Purpose: Return-address stack with pointer, entries, flag stack and fault reset.
// Assumes: The sequencer presents one operation per instruction cycle on op_in.
// Notes: Program counter, address register and data buffer updates are registered here.
`timescale 1ns/1ns

module return_address_stack #(
    parameter int PC_WIDTH = ras_pkg::PC_WIDTH,
    parameter int ENTRIES = ras_pkg::ENTRY_COUNT,
    parameter int ROM_WIDTH = ras_pkg::ROM_WIDTH
)
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire ras_pkg::stack_op_type op_in,
    input wire logic [PC_WIDTH-1:0] target_in,
    input wire logic [PC_WIDTH-1:0] vector_in,
    input wire logic [PC_WIDTH-1:0] next_pc_in,
    input wire logic [ROM_WIDTH-1:0] rom_data_in,
    input wire logic [ras_pkg::FLAG_WIDTH-1:0] status_flag_word_in,
    input wire logic address_reg_load_in,
    input wire logic [PC_WIDTH-1:0] address_reg_data_in,
    output logic [PC_WIDTH-1:0] program_counter_out,
    output logic [PC_WIDTH-1:0] program_address_reg_out,
    output logic [ROM_WIDTH-1:0] table_data_buffer_out,
    output logic [ras_pkg::FLAG_WIDTH-1:0] status_flag_word_out,
    output logic flags_restore_out,
    output logic skip_next_out,
    output logic table_busy_out,
    output logic [2:0] stack_pointer_out,
    output logic internal_reset_out
);
    logic [PC_WIDTH-1:0] return_addr_entry [ENTRIES];
    logic [PC_WIDTH-1:0] program_counter;
    logic [PC_WIDTH-1:0] program_address_reg;
    logic [ROM_WIDTH-1:0] table_data_buffer;
    logic skip_next;
    logic fault;
    logic flags_restore;
    logic saves_pc;
    logic restores_pc;
    logic entry_write;
    logic [PC_WIDTH-1:0] entry_data;
    logic [PC_WIDTH-1:0] selected_entry;
    logic [ras_pkg::FLAG_WIDTH-1:0] flag_top;
    logic [ras_pkg::FLAG_WIDTH-1:0] restored_flags;
    ras_pkg::table_state_type table_state;
    stack_pointer_if sp_bus ();

    // Entry index guarded so that an out-of-range pointer reads entry zero.
    function automatic int unsigned entry_index(input logic [2:0] p);
        entry_index = (int'(p) < ENTRIES) ? int'(p) : 0;
    endfunction : entry_index

    stack_pointer_unit u_pointer (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .sp(sp_bus)
    );

    interrupt_flag_stack #(
        .LEVELS(ras_pkg::FLAG_LEVELS),
        .WIDTH(ras_pkg::FLAG_WIDTH)
    ) u_flags (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .save_in(op_in == ras_pkg::OP_INTERRUPT),
        .restore_in(op_in == ras_pkg::OP_RETURN_INT),
        .flags_in(status_flag_word_in),
        .flags_out(flag_top)
    );

    // Classify the operation into pointer steps and entry traffic.
    always_comb
    begin
        saves_pc = (op_in == ras_pkg::OP_CALL) || (op_in == ras_pkg::OP_INTERRUPT)
            || (op_in == ras_pkg::OP_TABLE_FIRST);
        restores_pc = (op_in == ras_pkg::OP_RETURN) || (op_in == ras_pkg::OP_RETURN_SKIP)
            || (op_in == ras_pkg::OP_RETURN_INT) || (op_in == ras_pkg::OP_TABLE_SECOND);
        entry_write = saves_pc || (op_in == ras_pkg::OP_PUSH);
        sp_bus.dec = entry_write;
        sp_bus.inc = restores_pc || (op_in == ras_pkg::OP_POP);
        entry_data = (op_in == ras_pkg::OP_PUSH) ? program_address_reg : next_pc_in;
    end

    // Reads use the pointer before increment; writes use it after decrement.
    assign selected_entry = return_addr_entry[entry_index(sp_bus.value)];

    // Stack entries; the write lands at the already decremented pointer.
    always_ff @(posedge clock_in)
    begin
        if (entry_write)
            return_addr_entry[entry_index(sp_bus.next_value)] <= entry_data;
    end

    // Program counter loads per operation.
    always_ff @(posedge clock_in)
    begin
        if (srst_in || fault)
            program_counter <= '0;
        else
        begin
            case (op_in)
                ras_pkg::OP_CALL: program_counter <= target_in;
                ras_pkg::OP_INTERRUPT: program_counter <= vector_in;
                ras_pkg::OP_TABLE_FIRST: program_counter <= program_address_reg;
                ras_pkg::OP_RETURN,
                ras_pkg::OP_RETURN_SKIP,
                ras_pkg::OP_RETURN_INT,
                ras_pkg::OP_TABLE_SECOND: program_counter <= selected_entry;
                default: program_counter <= next_pc_in;
            endcase
        end
    end

    // Address register: pop loads from the stack, otherwise the core may load it.
    always_ff @(posedge clock_in)
    begin
        if (srst_in || fault)
            program_address_reg <= '0;
        else if (op_in == ras_pkg::OP_POP)
            program_address_reg <= selected_entry;
        else if (address_reg_load_in)
            program_address_reg <= address_reg_data_in;
    end

    // Table buffer captures ROM at the PC loaded in the first cycle.
    always_ff @(posedge clock_in)
    begin
        if (srst_in || fault)
            table_data_buffer <= '0;
        else if (op_in == ras_pkg::OP_TABLE_SECOND)
            table_data_buffer <= rom_data_in;
    end

    // Tracks the two-cycle table read so the sequencer holds its fetch.
    always_ff @(posedge clock_in)
    begin
        if (srst_in || fault)
            table_state <= ras_pkg::TABLE_IDLE;
        else
        begin
            case (table_state)
                ras_pkg::TABLE_IDLE:
                    if (op_in == ras_pkg::OP_TABLE_FIRST)
                        table_state <= ras_pkg::TABLE_FETCH;
                ras_pkg::TABLE_FETCH:
                    if (op_in == ras_pkg::OP_TABLE_SECOND)
                        table_state <= ras_pkg::TABLE_IDLE;
                default: table_state <= ras_pkg::TABLE_IDLE;
            endcase
        end
    end

    // Skip marker: the next fetched instruction is executed as no-operation.
    always_ff @(posedge clock_in)
    begin
        if (srst_in || fault)
            skip_next <= 1'b0;
        else
            skip_next <= (op_in == ras_pkg::OP_RETURN_SKIP);
    end

    // Flag restore strobe lines up with the restored PC.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            flags_restore <= 1'b0;
        else
            flags_restore <= (op_in == ras_pkg::OP_RETURN_INT);
    end

    // Restored flags are held in a flop so that they stand while the restore strobe is high.
    // The ring has already stepped down by then, so its top is no longer the right word.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            restored_flags <= '0;
        else if (op_in == ras_pkg::OP_RETURN_INT)
            restored_flags <= flag_top;
    end

    // Fault reset is registered to avoid a combinational loop back into the core.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            fault <= 1'b0;
        else
            fault <= (sp_bus.underflow && saves_pc)
                || (sp_bus.next_value >= ras_pkg::SP_LIMIT);
    end

    // Outputs from flops; the pointer itself is not cleared by the fault here.
    assign program_counter_out = program_counter;
    assign program_address_reg_out = program_address_reg;
    assign table_data_buffer_out = table_data_buffer;
    assign flags_restore_out = flags_restore;
    assign status_flag_word_out = restored_flags;
    assign skip_next_out = skip_next;
    assign table_busy_out = (table_state == ras_pkg::TABLE_FETCH);
    assign stack_pointer_out = sp_bus.value;
    assign internal_reset_out = fault;
endmodule : return_address_stack

// *** verification/return_address_stack_asserts.sv ***
// Purpose: Concurrent checks on the return-address stack ports.
// Assumes: One clock, synchronous active-high reset.
// Notes: Checks other than the fault and reset-pointer checks pause while a fault is pending, since a fault clears state.
`timescale 1ns/1ns
module return_address_stack_asserts #(
    parameter int PC_WIDTH = 11,
    parameter int ROM_WIDTH = 16
)
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire ras_pkg::stack_op_type op_in,
    input wire logic [PC_WIDTH-1:0] target_in,
    input wire logic [PC_WIDTH-1:0] vector_in,
    input wire logic [ROM_WIDTH-1:0] rom_data_in,
    input wire logic [PC_WIDTH-1:0] program_counter_out,
    input wire logic [PC_WIDTH-1:0] program_address_reg_out,
    input wire logic [ROM_WIDTH-1:0] table_data_buffer_out,
    input wire logic flags_restore_out,
    input wire logic skip_next_out,
    input wire logic table_busy_out,
    input wire logic [2:0] stack_pointer_out,
    input wire logic internal_reset_out
);
    // A healthy cycle has no fault pending and a pointer below SP_LIMIT, at most one above the top entry.
    wire ok = !internal_reset_out && stack_pointer_out < ras_pkg::SP_LIMIT;
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    chk_call_load: assert property (op_in == ras_pkg::OP_CALL && ok |=>
        program_counter_out == $past(target_in)
        && stack_pointer_out == $past(stack_pointer_out) - 3'h1) else $error("bad call");
    chk_return_step: assert property (ok &&
        op_in inside {ras_pkg::OP_RETURN, ras_pkg::OP_RETURN_SKIP}
        |=> stack_pointer_out == $past(stack_pointer_out) + 3'h1) else $error("bad return");
    chk_skip_pulse: assert property (!$past(srst_in) && $past(ok) |->
        skip_next_out == ($past(op_in) == ras_pkg::OP_RETURN_SKIP)) else $error("bad skip");
    chk_table_first: assert property (op_in == ras_pkg::OP_TABLE_FIRST && ok |=>
        program_counter_out == $past(program_address_reg_out) && table_busy_out)
        else $error("bad table first");
    chk_table_data: assert property (op_in == ras_pkg::OP_TABLE_SECOND && ok |=>
        table_data_buffer_out == $past(rom_data_in) && !table_busy_out)
        else $error("bad table data");
    chk_vector_load: assert property (op_in == ras_pkg::OP_INTERRUPT && ok |=>
        program_counter_out == $past(vector_in)) else $error("bad vector");
    chk_restore_pulse: assert property (!$past(srst_in) && $past(ok) |->
        flags_restore_out == ($past(op_in) == ras_pkg::OP_RETURN_INT)) else $error("bad restore");
    chk_wrap_fault: assert property (stack_pointer_out == 3'h0 &&
        op_in inside {ras_pkg::OP_CALL, ras_pkg::OP_TABLE_FIRST, ras_pkg::OP_INTERRUPT}
        |-> ##[1:2] internal_reset_out) else $error("no wrap fault");
    chk_limit_fault: assert property (stack_pointer_out >= ras_pkg::SP_LIMIT |->
        ##[0:1] internal_reset_out) else $error("no limit fault");
    chk_reset_pointer: assert property ($past(srst_in) |->
        stack_pointer_out == ras_pkg::SP_RESET) else $error("bad reset pointer");
endmodule : return_address_stack_asserts

bind return_address_stack return_address_stack_asserts #(
    .PC_WIDTH(PC_WIDTH), .ROM_WIDTH(ROM_WIDTH)) chk_inst (
    .clock_in(clock_in), .srst_in(srst_in), .op_in(op_in), .target_in(target_in),
    .vector_in(vector_in), .rom_data_in(rom_data_in),
    .program_counter_out(program_counter_out),
    .program_address_reg_out(program_address_reg_out),
    .table_data_buffer_out(table_data_buffer_out), .flags_restore_out(flags_restore_out),
    .skip_next_out(skip_next_out), .table_busy_out(table_busy_out),
    .stack_pointer_out(stack_pointer_out), .internal_reset_out(internal_reset_out));

// *** verification/program_rom_model.sv ***
// Purpose: Program memory stand-in answering the table read fetch.
// Assumes: The word is ready in the cycle its address appears.
// Notes: Each word derives from its address, so every location differs.
`timescale 1ns/1ns
module program_rom_model
(
    input wire logic [10:0] addr_in,
    output logic [15:0] data_out
);
    // Fixed upper bits keep a word from passing for a saved address.
    assign data_out = {5'h15, addr_in ^ 11'h2A5};
endmodule : program_rom_model

// *** verification/return_address_stack_tb.sv ***
// Purpose: Self-checking bench for the return-address stack.
// Assumes: Inputs change at the falling edge; one operation per cycle.
// Notes: A saved address is the operand with every bit inverted, except a push, which saves the address register.
`timescale 1ns/1ns
module return_address_stack_tb;
    logic clock_in = 1'h0;
    logic srst_in;
    ras_pkg::stack_op_type op_in;
    logic [10:0] target_in, vector_in, next_pc_in, pc, ar;
    logic [15:0] rom_data_in, dbf;
    logic [4:0] status_flag_word_in = 5'h00;
    logic [4:0] flags;
    logic address_reg_load_in = 1'h0;
    logic [10:0] address_reg_data_in = 11'h000;
    logic restore, skip, busy, fault;
    logic [2:0] sp;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    return_address_stack uut (.clock_in(clock_in), .srst_in(srst_in), .op_in(op_in),
        .target_in(target_in), .vector_in(vector_in), .next_pc_in(next_pc_in),
        .rom_data_in(rom_data_in), .status_flag_word_in(status_flag_word_in),
        .address_reg_load_in(address_reg_load_in), .address_reg_data_in(address_reg_data_in),
        .program_counter_out(pc), .program_address_reg_out(ar), .table_data_buffer_out(dbf),
        .status_flag_word_out(flags), .flags_restore_out(restore), .skip_next_out(skip),
        .table_busy_out(busy), .stack_pointer_out(sp), .internal_reset_out(fault));
    program_rom_model rom (.addr_in(pc), .data_out(rom_data_in));

    // The 20 MHz instruction clock.
    initial
    begin
        forever #25 clock_in = ~clock_in;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One operation for one edge; returns at the next falling edge.
    task automatic step(input ras_pkg::stack_op_type o, input logic [10:0] v);
        op_in = o;
        target_in = v;
        vector_in = v;
        next_pc_in = v ^ 11'h7FF;
        @(negedge clock_in);
    endtask : step

    task automatic do_reset();
        srst_in = 1'h1;
        repeat (3) step(ras_pkg::OP_NONE, 11'h000);
        srst_in = 1'h0;
        chk(sp, 16'h0005);
        chk({pc, fault}, 16'h0000);
    endtask : do_reset

    task automatic load_ar(input logic [10:0] v);
        address_reg_load_in = 1'h1;
        address_reg_data_in = v;
        step(ras_pkg::OP_NONE, 11'h000);
        address_reg_load_in = 1'h0;
    endtask : load_ar

    task automatic t_call_ret();
        step(ras_pkg::OP_CALL, 11'h123);
        chk({sp, pc}, {5'h04, 11'h123});
        step(ras_pkg::OP_CALL, 11'h456);
        chk({sp, pc}, {5'h03, 11'h456});
        step(ras_pkg::OP_RETURN, 11'h000);
        chk({sp, pc}, {5'h04, 11'h3A9});
        step(ras_pkg::OP_RETURN_SKIP, 11'h000);
        chk({skip, sp, pc}, {5'h0D, 11'h6DC});
        step(ras_pkg::OP_NONE, 11'h000);
        chk(skip, 16'h0000);
        $display("call and return done");
    endtask : t_call_ret

    task automatic t_table();
        load_ar(11'h2B4);
        step(ras_pkg::OP_TABLE_FIRST, 11'h1F0);
        chk({busy, sp, pc}, {5'h0C, 11'h2B4});
        step(ras_pkg::OP_TABLE_SECOND, 11'h000);
        chk(dbf, 16'hA811);
        chk({busy, sp, pc}, {5'h05, 11'h60F});
        $display("table read done");
    endtask : t_table

    task automatic t_int();
        for (int i = 0; i < 4; i++)
        begin
            status_flag_word_in = 5'h11 + 5'(i);
            step(ras_pkg::OP_INTERRUPT, 11'h040 + 11'(i));
            chk(pc, 16'h0040 + 16'(i));
            chk(sp, 16'h0004 - 16'(i));
        end
        // The restored word stands with the restore strobe; the oldest set is lost.
        for (int i = 3; i >= 0; i--)
        begin
            step(ras_pkg::OP_RETURN_INT, 11'h000);
            chk(restore, 16'h0001);
            if (i > 0)
                chk(flags, 16'h0011 + 16'(i));
            chk({sp, pc ^ 11'h7FF}, {5'h05 - 5'(i), 11'h040 + 11'(i)});
        end
        $display("interrupt nesting done");
    endtask : t_int

    task automatic t_push_pop();
        load_ar(11'h5A5);
        step(ras_pkg::OP_PUSH, 11'h000);
        chk(sp, 16'h0004);
        load_ar(11'h0F0);
        step(ras_pkg::OP_POP, 11'h000);
        chk({sp, ar}, {5'h05, 11'h5A5});
        $display("push and pop done");
    endtask : t_push_pop

    // Underflow by a sixth call, then an overflow by a return at the top.
    task automatic t_fault();
        repeat (5) step(ras_pkg::OP_CALL, 11'h100);
        chk({sp, fault}, 16'h0000);
        step(ras_pkg::OP_CALL, 11'h100);
        step(ras_pkg::OP_NONE, 11'h000);
        chk({sp, fault}, 16'h000F);
        do_reset();
        step(ras_pkg::OP_RETURN, 11'h000);
        step(ras_pkg::OP_NONE, 11'h000);
        chk({sp, fault}, 16'h000D);
        do_reset();
        $display("fault reset done");
    endtask : t_fault

    // Cuts a hang short well beyond the expected 38 cycles.
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    initial
    begin
        do_reset();
        t_call_ret();
        t_table();
        t_int();
        t_push_pop();
        t_fault();
        end_of_test();
    end
endmodule : return_address_stack_tb
